// >>> src/omi_interlock.sv
// overload manoeuvre interlock, lamps, display view and override timing
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/100ps
module omi_interlock #(
  parameter int unsigned TICK_CYCLES = omi_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // operator levers and buttons
  input  wire logic [14:0] lever_cmd,
  input  wire logic        stop_btn,
  input  wire logic        view_btn,
  input  wire logic        override_btn,
  input  wire logic        danger_btn,
  // limiter and crane sensors
  input  wire logic [7:0]  moment_pct,
  input  wire logic        crane_trip,
  input  wire logic        jib_trip,
  input  wire logic        winch_trip,
  input  wire logic        outer_above_hz,
  input  wire logic        ext_retracted,
  input  wire logic        jext_retracted,
  input  wire logic        ext_stroke_press,
  input  wire logic        jext_stroke_press,
  input  wire logic        rams_stroke_end,
  input  wire logic        load_absent,
  input  wire logic        fault_in,
  // valves, lamps, horn, display
  output logic      [14:0] valve_en,
  output logic             lamp_green,
  output logic             lamp_yellow,
  output logic             lamp_red,
  output logic             moment_override_lamp,
  output logic             horn,
  output logic      [1:0]  disp_page,
  output logic             disp_star,
  output logic             disp_fault
);
  localparam logic [14:0] TICK_LAST = 15'(TICK_CYCLES - 1);

  // reset release through two flops
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // ---------------- tick, blink and view state ----------------
  logic [14:0]        tick_cnt_q, tick_cnt_d;
  logic               tick;
  logic [7:0]         blink_q, blink_d;
  logic               flash_q, flash_d;
  logic [15:0]        ver_q, ver_d;
  omi_pkg::omi_page_t page_q, page_d;
  logic               view_prev_q;
  logic               psi_q, psi_d;
  logic [31:0]        rdata_q, rdata_d;
  logic [31:0]        status_w;

  assign tick = (tick_cnt_q == TICK_LAST);

  // tick divider, blink phase, power-on version, view cycling, registers
  always_comb begin
    tick_cnt_d = tick ? 15'h0000 : tick_cnt_q + 15'h0001;
    blink_d    = blink_q;
    flash_d    = flash_q;
    if (tick) begin
      blink_d = blink_q + 8'h01;
      if (blink_q == omi_pkg::BLINK_TK - 8'h01) begin
        blink_d = 8'h00;
        flash_d = ~flash_q;
      end
    end
    ver_d  = ver_q;
    page_d = page_q;
    if (page_q == omi_pkg::PG_VER) begin
      // version stays up a while before measurements appear
      if (tick) ver_d = ver_q - 16'h0001;
      if (tick && ver_q == 16'h0001) page_d = omi_pkg::PG_PRESS;
    end else if (view_btn && !view_prev_q) begin
      case (page_q)
        omi_pkg::PG_PRESS: page_d = omi_pkg::PG_PCT;
        omi_pkg::PG_PCT:   page_d = omi_pkg::PG_ALT;
        omi_pkg::PG_ALT:   page_d = omi_pkg::PG_PRESS;
        default:           page_d = omi_pkg::PG_PRESS;
      endcase
    end
    psi_d = psi_q;
    if (reg_wr && reg_addr == omi_pkg::A_CTRL) begin
      psi_d = reg_wdata[omi_pkg::CTRL_PSI];
    end
    rdata_d = 32'h0000_0000;  // unmapped addresses read zero
    if (reg_rd) begin
      case (reg_addr)
        omi_pkg::A_CTRL:   rdata_d = {31'h0000_0000, psi_q};
        omi_pkg::A_STATUS: rdata_d = status_w;
        omi_pkg::A_VER:    rdata_d = omi_pkg::SW_VERSION;
        default:           rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ---------------- interlock and override state ----------------
  omi_pkg::omi_ov_t ov_q, ov_d;
  logic [15:0] tmr_q, tmr_d;
  logic [15:0] lock_q, lock_d;
  logic        armed_q, armed_d;
  logic        ovl_q;
  logic        fault_q, fault_d;
  logic [14:0] valve_d;
  logic        ovl;
  logic        peak;
  logic        eligible;
  logic [14:0] allow;
  logic [14:0] perm;
  logic [14:0] forb;

  assign ovl  = crane_trip | jib_trip | winch_trip;
  // loadless trip with rams parked at stroke end is a pressure spike
  assign peak = load_absent & rams_stroke_end & ext_retracted;
  // an override only makes sense when nothing permitted can move
  assign eligible = ovl & ext_retracted & jext_retracted
                  & (lock_q == 16'h0000) & !fault_q;
  assign status_w = {23'h00_0000, (lock_q != 16'h0000), page_q,
                     ov_q, fault_q, armed_q, ovl};

  // allowed manoeuvre set for the present overload cause
  always_comb begin
    if (!ovl) begin
      allow = omi_pkg::M_ALL;
    end else if (winch_trip) begin
      allow = omi_pkg::M_WINCH;
    end else begin
      allow = outer_above_hz ? omi_pkg::M_ABOVE
                             : omi_pkg::M_BELOW;
      if (jib_trip && !crane_trip) begin
        allow = allow | omi_pkg::M_EXT_OUT;
      end
      if (peak) allow = allow | omi_pkg::M_PEAK;
    end
    if (!ovl) begin
      perm = lever_cmd;
      forb = 15'h0000;
    end else begin
      perm = lever_cmd & allow & ~omi_pkg::M_ACC;
      forb = lever_cmd & ~allow & ~omi_pkg::M_ACC;
    end
  end

  // next state of override sequence, timers, arming and valves
  always_comb begin
    ov_d    = ov_q;
    tmr_d   = (tick && tmr_q != 16'h0000) ? tmr_q - 16'h0001 : tmr_q;
    lock_d  = (tick && lock_q != 16'h0000) ? lock_q - 16'h0001 : lock_q;
    armed_d = armed_q;
    // new overload needs a fresh return to neutral
    if (!ovl || !ovl_q) armed_d = 1'b0;
    else if (lever_cmd == 15'h0000) armed_d = 1'b1;
    else if (forb != 15'h0000) armed_d = 1'b0;
    // set wins over the clear when a fault is still present
    fault_d = fault_q;
    if (override_btn) fault_d = 1'b0;
    if (fault_in) fault_d = 1'b1;
    case (ov_q)
      omi_pkg::OV_IDLE: begin
        if (eligible && (lever_cmd & omi_pkg::M_EXT_IN) != 15'h0000
            && ext_stroke_press) begin
          ov_d = omi_pkg::OV_FLASH;
        end else if (eligible
            && (lever_cmd & omi_pkg::M_JEXT_IN) != 15'h0000
            && jext_stroke_press) begin
          ov_d = omi_pkg::OV_JFL;
        end
      end
      omi_pkg::OV_JFL: begin
        if ((lever_cmd & omi_pkg::M_JEXT_IN) == 15'h0000) begin
          ov_d  = omi_pkg::OV_JWAIT;
          tmr_d = omi_pkg::JIB_WIN_TK;
        end
      end
      omi_pkg::OV_JWAIT: begin
        if ((lever_cmd & omi_pkg::M_JEXT_IN) != 15'h0000) begin
          ov_d = omi_pkg::OV_JHOLD;
        end else if (tmr_q == 16'h0000) begin
          ov_d = omi_pkg::OV_IDLE;
        end
      end
      omi_pkg::OV_JHOLD: begin
        if ((lever_cmd & omi_pkg::M_JEXT_IN) == 15'h0000) begin
          ov_d = omi_pkg::OV_IDLE;
        end else if (jext_stroke_press) begin
          ov_d = omi_pkg::OV_FLASH;
        end
      end
      omi_pkg::OV_FLASH: begin
        if (!ovl || (lever_cmd & (omi_pkg::M_EXT_IN
            | omi_pkg::M_JEXT_IN)) == 15'h0000) begin
          ov_d = omi_pkg::OV_IDLE;
        end else if (override_btn
            && (lever_cmd & omi_pkg::M_EXT_IN) != 15'h0000) begin
          ov_d   = omi_pkg::OV_GRANT;
          tmr_d  = omi_pkg::GRANT_TK;
          lock_d = omi_pkg::LOCK_TK;
        end
      end
      omi_pkg::OV_GRANT: begin
        if (tmr_q == 16'h0000) ov_d = omi_pkg::OV_IDLE;
      end
      default: ov_d = omi_pkg::OV_IDLE;
    endcase
    // valve gating
    if (ov_q == omi_pkg::OV_GRANT) begin
      valve_d = lever_cmd & omi_pkg::M_OUT_DN;
    end else if (!ovl) begin
      valve_d = lever_cmd;
    end else if (armed_q && forb == 15'h0000) begin
      valve_d = perm;
      if (perm != 15'h0000) begin
        valve_d = perm | (lever_cmd & omi_pkg::M_ACC);
      end
    end else begin
      valve_d = 15'h0000;
    end
    if (stop_btn || fault_q) valve_d = 15'h0000;
  end

  // registers of both groups and the registered outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q           <= 15'h0000;
      blink_q              <= 8'h00;
      flash_q              <= 1'b0;
      ver_q                <= omi_pkg::VER_TK;
      page_q               <= omi_pkg::PG_VER;
      view_prev_q          <= 1'b0;
      psi_q                <= 1'b0;
      rdata_q              <= 32'h0000_0000;
      ov_q                 <= omi_pkg::OV_IDLE;
      tmr_q                <= 16'h0000;
      lock_q               <= 16'h0000;
      armed_q              <= 1'b0;
      ovl_q                <= 1'b0;
      fault_q              <= 1'b0;
      valve_en             <= 15'h0000;
      lamp_green           <= 1'b0;
      lamp_yellow          <= 1'b0;
      lamp_red             <= 1'b0;
      moment_override_lamp <= 1'b0;
      horn                 <= 1'b0;
      disp_page            <= 2'h0;
      disp_star            <= 1'b0;
      disp_fault           <= 1'b0;
    end else begin
      tick_cnt_q  <= tick_cnt_d;
      blink_q     <= blink_d;
      flash_q     <= flash_d;
      ver_q       <= ver_d;
      page_q      <= page_d;
      view_prev_q <= view_btn;
      psi_q       <= psi_d;
      rdata_q     <= rdata_d;
      ov_q        <= ov_d;
      tmr_q       <= tmr_d;
      lock_q      <= lock_d;
      armed_q     <= armed_d;
      ovl_q       <= ovl;
      fault_q     <= fault_d;
      valve_en    <= valve_d;
      // band: red overrides yellow, both tracked on the same sample
      lamp_red    <= ovl | (moment_pct > omi_pkg::PCT_RATED);
      lamp_yellow <= !ovl && moment_pct >= omi_pkg::PCT_YELLOW
                     && moment_pct <= omi_pkg::PCT_RATED;
      lamp_green  <= !ovl && moment_pct < omi_pkg::PCT_YELLOW;
      // flashes while waiting, dark on renewed jib retraction
      case (ov_q)
        omi_pkg::OV_JFL,
        omi_pkg::OV_JWAIT,
        omi_pkg::OV_FLASH: moment_override_lamp <= flash_q;
        omi_pkg::OV_GRANT: moment_override_lamp <= 1'b1;
        default:           moment_override_lamp <= 1'b0;
      endcase
      horn        <= danger_btn;
      disp_page   <= page_q;
      // marker flips for the non-standard view
      disp_star   <= (page_q == omi_pkg::PG_ALT) ? !psi_q : psi_q;
      disp_fault  <= fault_q;
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_STOP: assert property (stop_btn |=> valve_en == 15'h0000)
    else $error("valve enabled after stop");
  AST_YELLOW: assert property (!ovl && moment_pct >= 8'h5A
      && moment_pct <= 8'h64 |=> lamp_yellow && !lamp_red)
    else $error("yellow lamp not lit at ninety percent");
  AST_RED: assert property (ovl |=> lamp_red && !lamp_green)
    else $error("red lamp missing in overload");
  AST_DANGER: assert property ($rose(danger_btn) |=> $rose(horn))
    else $error("horn did not follow danger button");
  AST_MIXED: assert property (ovl && forb != 15'h0000
      && ov_q != omi_pkg::OV_GRANT |=> valve_en == 15'h0000)
    else $error("movement with a forbidden command");
  AST_NEUTRAL: assert property (ovl && !ovl_q
      && ov_q != omi_pkg::OV_GRANT
      |=> ##1 !armed_q || $past(lever_cmd) == 15'h0000)
    else $error("armed without neutral levers");
  AST_ABOVE: assert property (crane_trip && !winch_trip
      && outer_above_hz && !peak && ov_q != omi_pkg::OV_GRANT
      |=> (valve_en & ~omi_pkg::M_ABOVE & ~omi_pkg::M_ACC) == 15'h0000)
    else $error("blocked manoeuvre enabled above horizontal");
  AST_GRANT: assert property (ov_q == omi_pkg::OV_GRANT
      |=> (valve_en & ~omi_pkg::M_OUT_DN) == 15'h0000)
    else $error("more than outer descent during override");
  AST_LOCK: assert property (ov_q != omi_pkg::OV_GRANT
      ##1 ov_q == omi_pkg::OV_GRANT |-> lock_q == omi_pkg::LOCK_TK
      && tmr_q == omi_pkg::GRANT_TK)
    else $error("override timers not loaded on grant");
  AST_FAULT: assert property (fault_in
      |=> ##1 valve_en == 15'h0000 && disp_fault)
    else $error("fault did not stop functions");
  AST_VIEW: assert property (page_q == omi_pkg::PG_PRESS
      && view_btn && !view_prev_q |=> page_q == omi_pkg::PG_PCT)
    else $error("view button did not advance");

  COV_GRANT: cover property (ov_q == omi_pkg::OV_GRANT);
  COV_JIB: cover property (ov_q == omi_pkg::OV_JHOLD
      ##1 ov_q == omi_pkg::OV_FLASH);
  COV_ALT: cover property (page_q == omi_pkg::PG_ALT);
  COV_OVL_MOVE: cover property (ovl && valve_en != 15'h0000);
endmodule

// >>> src/omi_pkg.sv
// constants for the overload manoeuvre interlock
package omi_pkg;
  // clock and tick base
  localparam int unsigned CLK_HZ   = 20_000_000;
  localparam int unsigned TICK_US  = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;

  // intervals in their printed units, then in ticks
  localparam int unsigned JIB_WIN_S = 3;
  localparam int unsigned GRANT_S   = 5;
  localparam int unsigned LOCK_MIN  = 1;
  localparam int unsigned VER_MS    = 2000;
  localparam int unsigned BLINK_MS  = 250;
  localparam logic [15:0] JIB_WIN_TK = 16'(JIB_WIN_S * 1_000_000 / TICK_US);
  localparam logic [15:0] GRANT_TK   = 16'(GRANT_S * 1_000_000 / TICK_US);
  localparam logic [15:0] LOCK_TK    =
    16'(LOCK_MIN * 60 * 1_000_000 / TICK_US);
  localparam logic [15:0] VER_TK     = 16'(VER_MS * 1000 / TICK_US);
  localparam logic [7:0]  BLINK_TK   = 8'(BLINK_MS * 1000 / TICK_US);

  // load percentage thresholds
  localparam logic [7:0] PCT_YELLOW = 8'h5A;  // 90
  localparam logic [7:0] PCT_RATED  = 8'h64;  // 100

  // manoeuvre bits: 0 rot cw, 1 rot ccw, 2 inner up, 3 inner down,
  // 4 outer up, 5 outer down, 6 ext out, 7 ext in, 8 jib up, 9 jib down,
  // 10 jib ext out, 11 jib ext in, 12 rope lift, 13 rope down, 14 accessory
  localparam int unsigned NMAN = 15;
  localparam logic [14:0] M_ALL      = 15'h7FFF;
  localparam logic [14:0] M_OUT_DN   = 15'h0020;
  localparam logic [14:0] M_EXT_OUT  = 15'h0040;
  localparam logic [14:0] M_EXT_IN   = 15'h0080;
  localparam logic [14:0] M_JEXT_IN  = 15'h0800;
  localparam logic [14:0] M_ACC      = 15'h4000;
  localparam logic [14:0] M_ABOVE    = 15'h2897;
  localparam logic [14:0] M_BELOW    = 15'h2AAB;
  localparam logic [14:0] M_WINCH    = 15'h2883;
  localparam logic [14:0] M_PEAK     = 15'h0228;

  // register map
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_VER    = 8'h08;
  localparam int unsigned CTRL_PSI = 0;
  localparam logic [31:0] SW_VERSION = 32'h0000_0101;  // arbitrary value

  // display pages
  typedef enum logic [1:0] {
    PG_VER = 2'h0, PG_PRESS = 2'h1, PG_PCT = 2'h2, PG_ALT = 2'h3
  } omi_page_t;

  // override sequence, gray along the jib path from OV_IDLE up to OV_GRANT
  typedef enum logic [2:0] {
    OV_IDLE  = 3'h0,
    OV_JFL   = 3'h1,
    OV_JWAIT = 3'h3,
    OV_JHOLD = 3'h2,
    OV_FLASH = 3'h6,
    OV_GRANT = 3'h7
  } omi_ov_t;
endpackage

// >>> tb/omi_operator.sv
// operator hands on the levers plus distributor stroke-end pressure
`timescale 1ns/100ps
module omi_operator #(
  parameter int unsigned STROKE_CYC = 20
) (
  // clock
  input  wire logic        ref_clk,
  // operator intent and ram state
  input  wire logic [14:0] want,
  input  wire logic        ext_retracted,
  input  wire logic        jext_retracted,
  // towards the interlock
  output logic      [14:0] lever_cmd,
  output logic             ext_stroke_press,
  output logic             jext_stroke_press
);
  int unsigned hold_q = 0;

  initial lever_cmd = 15'h0000;

  // spool follows the hand a clock late; count how long it is held
  always @(posedge ref_clk) begin
    lever_cmd <= want;
    if (want != lever_cmd) begin
      hold_q <= 0;
    end else if (hold_q < STROKE_CYC) begin
      hold_q <= hold_q + 1;
    end
  end

  // pressure only once the retraction has run into its stroke end,
  // so a renewed retraction shows a gap before pressure returns
  assign ext_stroke_press  = want[7] && ext_retracted &&
                             hold_q >= STROKE_CYC;
  assign jext_stroke_press = want[11] && jext_retracted &&
                             hold_q >= STROKE_CYC;
endmodule

// >>> tb/omi_interlock_bench.sv
// self-checking bench for the overload manoeuvre interlock
`timescale 1ns/100ps
module omi_interlock_bench;
  typedef struct packed {
    logic [2:0]  trip;  // 0 crane, 1 jib, 2 winch
    logic        above;
    logic        pk;
    logic [14:0] lev;
    logic [14:0] exp;
  } omi_row_t;
  localparam int unsigned NROW  = 16;
  localparam int unsigned T_LIM = 60000;
  localparam omi_row_t ROWS [NROW] = '{
    '{3'h0, 1'b1, 1'b0, 15'h3FFF, 15'h3FFF},
    '{3'h1, 1'b1, 1'b0, 15'h0004, 15'h0004},
    '{3'h1, 1'b1, 1'b0, 15'h0020, 15'h0000},
    '{3'h1, 1'b1, 1'b0, 15'h0024, 15'h0000},
    '{3'h1, 1'b1, 1'b0, 15'h2897, 15'h2897},
    '{3'h1, 1'b1, 1'b0, 15'h0040, 15'h0000},
    '{3'h1, 1'b1, 1'b0, 15'h4001, 15'h4001},
    '{3'h1, 1'b1, 1'b0, 15'h4000, 15'h0000},
    '{3'h1, 1'b0, 1'b0, 15'h0028, 15'h0028},
    '{3'h1, 1'b0, 1'b0, 15'h0010, 15'h0000},
    '{3'h1, 1'b0, 1'b0, 15'h0100, 15'h0000},
    '{3'h1, 1'b0, 1'b0, 15'h0200, 15'h0200},
    '{3'h2, 1'b0, 1'b0, 15'h0040, 15'h0040},
    '{3'h4, 1'b1, 1'b0, 15'h2883, 15'h2883},
    '{3'h4, 1'b0, 1'b0, 15'h0008, 15'h0000},
    '{3'h1, 1'b1, 1'b1, 15'h0020, 15'h0020}
  };

  // stimulus
  logic        ref_clk   = 1'b0;
  logic        arst_n    = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0, reg_rd = 1'b0;
  logic [14:0] want = 15'h0000;
  logic        stop_btn = 1'b0, view_btn = 1'b0, override_btn = 1'b0;
  logic        danger_btn = 1'b0, fault_in = 1'b0;
  logic [7:0]  moment_pct = 8'h00;
  logic        crane_trip = 1'b0, jib_trip = 1'b0, winch_trip = 1'b0;
  logic        outer_above_hz = 1'b0, load_absent = 1'b0;
  logic        ext_retracted = 1'b0, jext_retracted = 1'b0;
  logic        rams_stroke_end = 1'b0;
  // observed
  logic [31:0] reg_rdata;
  logic [14:0] lever_cmd, valve_en;
  logic        ext_stroke_press, jext_stroke_press;
  logic        lamp_green, lamp_yellow, lamp_red, moment_override_lamp;
  logic        horn, disp_star, disp_fault;
  logic [1:0]  disp_page;
  int unsigned err_count = 0, cmp_count = 0, cyc = 0, t0;
  bit          seen;

  omi_operator u_op (.ref_clk(ref_clk), .want(want),
    .ext_retracted(ext_retracted), .jext_retracted(jext_retracted),
    .lever_cmd(lever_cmd), .ext_stroke_press(ext_stroke_press),
    .jext_stroke_press(jext_stroke_press));

  // short tick keeps the version, jib and grant windows inside the run; the lockout outlasts it
  omi_interlock #(.TICK_CYCLES(4)) dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lever_cmd(lever_cmd),
    .stop_btn(stop_btn), .view_btn(view_btn), .override_btn(override_btn),
    .danger_btn(danger_btn), .moment_pct(moment_pct),
    .crane_trip(crane_trip), .jib_trip(jib_trip), .winch_trip(winch_trip),
    .outer_above_hz(outer_above_hz), .ext_retracted(ext_retracted),
    .jext_retracted(jext_retracted), .ext_stroke_press(ext_stroke_press),
    .jext_stroke_press(jext_stroke_press),
    .rams_stroke_end(rams_stroke_end), .load_absent(load_absent),
    .fault_in(fault_in), .valve_en(valve_en), .lamp_green(lamp_green),
    .lamp_yellow(lamp_yellow), .lamp_red(lamp_red),
    .moment_override_lamp(moment_override_lamp), .horn(horn),
    .disp_page(disp_page), .disp_star(disp_star), .disp_fault(disp_fault));

  always #25 ref_clk = ~ref_clk;

  // hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == T_LIM) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // called right at an edge: sees what the flops took one edge earlier
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic set_trip(input logic [2:0] t);
    crane_trip <= t[0];
    jib_trip   <= t[1];
    winch_trip <= t[2];
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    wt(1);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    wt(1);
    reg_rd   <= 1'b0;
    wt(1);
    chk(reg_rdata, exp);
  endtask

  task automatic press_view(input logic [1:0] pg);
    view_btn <= 1'b1;
    wt(1);
    view_btn <= 1'b0;
    wt(3);
    chk(32'(disp_page), 32'(pg));
  endtask

  // a flashing lamp is on for half of each 2000-cycle period
  task automatic wait_lamp(input int lim, output bit s);
    s = 1'b0;
    repeat (lim) begin
      @(posedge ref_clk);
      if (moment_override_lamp === 1'b1) s = 1'b1;
    end
  endtask

  initial begin
    wt(5);
    arst_n <= 1'b1;
    wt(4);
    chk(32'(valve_en), 32'h0000_0000);
    chk(32'(disp_page), 32'h0000_0000);
    moment_pct <= 8'h32;
    wt(3);
    chk(32'({lamp_green, lamp_yellow, lamp_red}), 32'h0000_0004);
    moment_pct <= 8'h5A;
    wt(3);
    chk(32'({lamp_green, lamp_yellow, lamp_red}), 32'h0000_0002);
    crane_trip <= 1'b1;
    wt(3);
    chk(32'(lamp_red), 32'h0000_0001);
    // manoeuvre table: fresh overload, neutral levers, then command
    for (int i = 0; i < NROW; i++) begin
      set_trip(3'h0);
      want <= 15'h0000;
      wt(3);
      set_trip(ROWS[i].trip);
      outer_above_hz  <= ROWS[i].above;
      load_absent     <= ROWS[i].pk;
      rams_stroke_end <= ROWS[i].pk;
      ext_retracted   <= ROWS[i].pk;
      wt(3);
      want <= ROWS[i].lev;
      wt(4);
      chk(32'(valve_en), 32'(ROWS[i].exp));
    end
    // overload arriving under a held lever stays locked until neutral
    set_trip(3'h0);
    outer_above_hz <= 1'b1;
    want <= 15'h0004;
    wt(4);
    crane_trip <= 1'b1;
    wt(4);
    chk(32'(valve_en), 32'h0000_0000);
    want <= 15'h0000;
    wt(3);
    want <= 15'h0004;
    wt(4);
    chk(32'(valve_en), 32'h0000_0004);
    // stop, fault and danger with no overload
    set_trip(3'h0);
    want <= 15'h0001;
    stop_btn <= 1'b1;
    wt(4);
    chk(32'(valve_en), 32'h0000_0000);
    stop_btn <= 1'b0;
    fault_in <= 1'b1;
    wt(4);
    chk(32'({disp_fault, valve_en}), 32'h0000_8000);
    fault_in <= 1'b0;
    wt(3);
    chk(32'(disp_fault), 32'h0000_0001);
    override_btn <= 1'b1;
    wt(1);
    override_btn <= 1'b0;
    wt(4);
    chk(32'({disp_fault, valve_en}), 32'h0000_0001);
    danger_btn <= 1'b1;
    wt(3);
    chk(32'(horn), 32'h0000_0001);
    danger_btn <= 1'b0;
    want <= 15'h0000;
    // version page gives way after 2000 ticks
    while (cyc < 8300) wt(1);
    chk(32'(disp_page), 32'h0000_0001);
    chk(32'(disp_star), 32'h0000_0000);
    wr(omi_pkg::A_CTRL, 32'h0000_0003);
    wt(3);
    chk(32'(disp_star), 32'h0000_0001);
    rd(omi_pkg::A_CTRL, 32'h0000_0001);
    rd(omi_pkg::A_VER, omi_pkg::SW_VERSION);
    rd(8'h0C, 32'h0000_0000);
    press_view(2'h2);
    press_view(2'h3);
    chk(32'(disp_star), 32'h0000_0000);
    press_view(2'h1);
    wr(omi_pkg::A_CTRL, 32'h0000_0000);
    wt(1);
    // jib override path, then the crane retraction and button;
    // loaded crane, so no peak widens the allowed set after the grant
    crane_trip <= 1'b1;
    load_absent     <= 1'b0;
    rams_stroke_end <= 1'b0;
    ext_retracted  <= 1'b1;
    jext_retracted <= 1'b1;
    wt(4);
    // missed window: the wait for a renewed retraction runs out
    want <= 15'h0800;
    wt(30);
    want <= 15'h0000;
    wt(10);
    rd(omi_pkg::A_STATUS, 32'h0000_005B);
    wt(12100);
    rd(omi_pkg::A_STATUS, 32'h0000_0043);
    want <= 15'h0800;
    wait_lamp(2100, seen);
    chk(32'(seen), 32'h0000_0001);
    want <= 15'h0000;
    wt(10);
    want <= 15'h0800;
    wt(5);
    chk(32'(moment_override_lamp), 32'h0000_0000);
    wait_lamp(2100, seen);
    chk(32'(seen), 32'h0000_0001);
    want <= 15'h0080;
    wt(30);
    override_btn <= 1'b1;
    wt(1);
    override_btn <= 1'b0;
    t0 = cyc;
    want <= 15'h0000;
    wt(4);
    chk(32'(moment_override_lamp), 32'h0000_0001);
    want <= 15'h0020;
    wt(4);
    chk(32'(valve_en), 32'h0000_0020);
    wt(1100);
    chk(32'(moment_override_lamp), 32'h0000_0001);
    want <= 15'h0004;
    wt(4);
    chk(32'(valve_en), 32'h0000_0000);
    want <= 15'h0020;
    while (cyc < t0 + 19900) wt(1);
    chk(32'(valve_en), 32'h0000_0020);
    while (cyc < t0 + 20200) wt(1);
    chk(32'(valve_en), 32'h0000_0000);
    // within the lockout a held crane retraction earns no flash
    want <= 15'h0000;
    wt(3);
    want <= 15'h0080;
    wait_lamp(2100, seen);
    chk(32'(seen), 32'h0000_0000);
    give_verdict();
  end
endmodule
